//--- include/lsv_pkg.sv
// Constants shared by the LCD supply voltage control block.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
package lsv_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_PUMP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TEMP_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PROG_CODE = 8'h08;
  localparam logic [7:0] ADDR_TEMP_OFFS = 8'h0c;
  localparam logic [7:0] ADDR_MUX_CTRL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_TARGET = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PUMP_ON_POS = 1;
  localparam int PUMP_MULT_POS = 0;
  localparam int TEMP_COMP_POS = 1;
  localparam int EXT_SUPPLY_POS = 0;
  localparam int ST_PUMP_RUN_POS = 0;
  localparam int ST_COMP_USED_POS = 1;
  localparam int ST_CONFLICT_POS = 2;
  localparam int ST_SEG_POS = 8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_PUMP_ON = 1'h0;
  localparam logic RST_PUMP_MULT = 1'h0;
  localparam logic RST_TEMP_COMP = 1'h1;
  localparam logic [7:0] RST_PROG_CODE = 8'h00;
  localparam logic [2:0] RST_MUX = 3'h0;

  // ----------------------------------------
  // Voltage scale: target in units of 10 mV
  // ----------------------------------------
  localparam logic [10:0] VOLT_STEP_CV = 11'h003;
  localparam logic [10:0] VOLT_BASE_CV = 11'h12c;
  localparam logic [10:0] VOLT_ZERO = 11'h000;

  // ----------------------------------------
  // Backplane count to segment count
  // ----------------------------------------
  localparam logic [2:0] MUX_BP8 = 3'h0;
  localparam logic [2:0] MUX_BP1 = 3'h1;
  localparam logic [2:0] MUX_BP2 = 3'h2;
  localparam logic [2:0] MUX_BP4 = 3'h3;
  localparam logic [2:0] MUX_BP6 = 3'h4;
  localparam logic [5:0] SEG_COUNT_6BP = 6'h2e;
  localparam logic [5:0] SEG_COUNT_STD = 6'h2c;

endpackage : lsv_pkg

//--- rtl/lsv_target_calc.sv
// Computes the pump target voltage from the programmed code and offset.
// Assumes code and offset come from registers on the same clock.
`timescale 1ns/10ps
module lsv_target_calc (
  input wire logic [7:0] prog_code_i,
  input wire logic [7:0] temp_offset_i,
  input wire logic comp_on_i,
  output logic [10:0] target_cv_o
);

  logic [10:0] prog_cv;
  logic [10:0] offs_cv;

  // ----------------------------------------
  // Programmed and offset parts
  // ----------------------------------------
  always_comb
  begin
    prog_cv = 11'({3'h0, prog_code_i} * lsv_pkg::VOLT_STEP_CV) + lsv_pkg::VOLT_BASE_CV;
    if (comp_on_i)
    begin
      offs_cv = 11'({{3{temp_offset_i[7]}}, temp_offset_i} * lsv_pkg::VOLT_STEP_CV);
    end
    else
    begin
      offs_cv = lsv_pkg::VOLT_ZERO;
    end
    target_cv_o = prog_cv + offs_cv;
  end

endmodule : lsv_target_calc

//--- rtl/lsv_supply_ctrl.sv
// LCD supply voltage control: pump enable, multiplier, programmed code, target.
// Assumes a classic Wishbone master on clk_i and a temperature offset from logic on clk_i.
//
// Behaviour
// - External drive voltage gets no temperature compensation, even if enabled.
// - Programmed code has no effect on an external drive voltage.
// - Pump produces at most three times its supply voltage.
// - Pump on bit switches the pump, multiplier bit selects its setting.
// - Internal target equals programmed voltage plus temperature offset.
// - Programmed voltage is code times 0.03 plus 3 volts.
// - Temperature offset is 8-bit two's complement, zero at 20 degrees.
// - Six backplanes give 46 segments, other counts give 44.
// - Pump is off after reset.
// - Temperature compensation is on after reset.
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
module lsv_supply_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] temp_offset_code_i,
  input wire logic pump_supply_ok_i,
  output logic pump_on_o,
  output logic pump_multiplier_select_o,
  output logic [10:0] target_cv_o,
  output logic [5:0] segment_count_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic pump_on_bit_r;
  logic pump_on_bit_nxt;
  logic pump_multiplier_select_r;
  logic pump_multiplier_select_nxt;
  logic temp_comp_on_bit_r;
  logic temp_comp_on_bit_nxt;
  logic ext_supply_r;
  logic ext_supply_nxt;
  logic [7:0] programmed_voltage_code_r;
  logic [7:0] programmed_voltage_code_nxt;
  logic [2:0] mux_r;
  logic [2:0] mux_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic ack_r;
  logic ack_nxt;
  logic pump_run_r;
  logic pump_run_nxt;
  logic mult_r;
  logic mult_nxt;
  logic [10:0] target_r;
  logic [10:0] target_nxt;
  logic [5:0] seg_r;
  logic [5:0] seg_nxt;
  logic [10:0] calc_cv;
  logic comp_used;
  logic wr_en;

  // ----------------------------------------
  // Target arithmetic
  // ----------------------------------------
  assign comp_used = temp_comp_on_bit_r && !ext_supply_r;

  lsv_target_calc i_lsv_target_calc (
    .prog_code_i(programmed_voltage_code_r),
    .temp_offset_i(temp_offset_code_i),
    .comp_on_i(comp_used),
    .target_cv_o(calc_cv)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    // Writes land at the edge where the master samples ack, never before it.
    wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    pump_on_bit_nxt = pump_on_bit_r;
    pump_multiplier_select_nxt = pump_multiplier_select_r;
    temp_comp_on_bit_nxt = temp_comp_on_bit_r;
    ext_supply_nxt = ext_supply_r;
    programmed_voltage_code_nxt = programmed_voltage_code_r;
    mux_nxt = mux_r;
    dat_nxt = 32'h0;
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    if (wr_en && wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        lsv_pkg::ADDR_PUMP_CTRL:
        begin
          pump_on_bit_nxt = wb_dat_i[lsv_pkg::PUMP_ON_POS];
          pump_multiplier_select_nxt = wb_dat_i[lsv_pkg::PUMP_MULT_POS];
        end
        lsv_pkg::ADDR_TEMP_CTRL:
        begin
          temp_comp_on_bit_nxt = wb_dat_i[lsv_pkg::TEMP_COMP_POS];
          ext_supply_nxt = wb_dat_i[lsv_pkg::EXT_SUPPLY_POS];
        end
        lsv_pkg::ADDR_PROG_CODE:
        begin
          programmed_voltage_code_nxt = wb_dat_i[7:0];
        end
        lsv_pkg::ADDR_MUX_CTRL:
        begin
          mux_nxt = wb_dat_i[2:0];
        end
        default:
        begin
        end
      endcase
    end
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r)
    begin
      unique case (wb_adr_i)
        lsv_pkg::ADDR_PUMP_CTRL:
        begin
          dat_nxt[lsv_pkg::PUMP_ON_POS] = pump_on_bit_r;
          dat_nxt[lsv_pkg::PUMP_MULT_POS] = pump_multiplier_select_r;
        end
        lsv_pkg::ADDR_TEMP_CTRL:
        begin
          dat_nxt[lsv_pkg::TEMP_COMP_POS] = temp_comp_on_bit_r;
          dat_nxt[lsv_pkg::EXT_SUPPLY_POS] = ext_supply_r;
        end
        lsv_pkg::ADDR_PROG_CODE:
        begin
          dat_nxt[7:0] = programmed_voltage_code_r;
        end
        lsv_pkg::ADDR_TEMP_OFFS:
        begin
          dat_nxt[7:0] = temp_offset_code_i;
        end
        lsv_pkg::ADDR_MUX_CTRL:
        begin
          dat_nxt[2:0] = mux_r;
        end
        lsv_pkg::ADDR_STATUS:
        begin
          dat_nxt[lsv_pkg::ST_PUMP_RUN_POS] = pump_run_r;
          dat_nxt[lsv_pkg::ST_COMP_USED_POS] = comp_used;
          dat_nxt[lsv_pkg::ST_CONFLICT_POS] = pump_on_bit_r && ext_supply_r;
          dat_nxt[lsv_pkg::ST_SEG_POS +: 6] = seg_r;
        end
        lsv_pkg::ADDR_TARGET:
        begin
          dat_nxt[10:0] = target_r;
        end
        default:
        begin
        end
      endcase
    end
    // The pump never starts against an external supply and stops one cycle after ext_supply_r sets, limiting the damage of a host slip.
    pump_run_nxt = pump_on_bit_r && !ext_supply_r && pump_supply_ok_i;
    mult_nxt = pump_multiplier_select_r;
    if (ext_supply_r)
    begin
      target_nxt = lsv_pkg::VOLT_ZERO;
    end
    else
    begin
      target_nxt = calc_cv;
    end
    if (mux_r == lsv_pkg::MUX_BP6)
    begin
      seg_nxt = lsv_pkg::SEG_COUNT_6BP;
    end
    else
    begin
      seg_nxt = lsv_pkg::SEG_COUNT_STD;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pump_on_bit_r <= lsv_pkg::RST_PUMP_ON;
      pump_multiplier_select_r <= lsv_pkg::RST_PUMP_MULT;
      temp_comp_on_bit_r <= lsv_pkg::RST_TEMP_COMP;
      ext_supply_r <= 1'h0;
      programmed_voltage_code_r <= lsv_pkg::RST_PROG_CODE;
      mux_r <= lsv_pkg::RST_MUX;
      dat_r <= 32'h0;
      ack_r <= 1'h0;
      pump_run_r <= 1'h0;
      mult_r <= lsv_pkg::RST_PUMP_MULT;
      target_r <= lsv_pkg::VOLT_ZERO;
      seg_r <= lsv_pkg::SEG_COUNT_STD;
    end
    else
    begin
      pump_on_bit_r <= pump_on_bit_nxt;
      pump_multiplier_select_r <= pump_multiplier_select_nxt;
      temp_comp_on_bit_r <= temp_comp_on_bit_nxt;
      ext_supply_r <= ext_supply_nxt;
      programmed_voltage_code_r <= programmed_voltage_code_nxt;
      mux_r <= mux_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      pump_run_r <= pump_run_nxt;
      mult_r <= mult_nxt;
      target_r <= target_nxt;
      seg_r <= seg_nxt;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign pump_on_o = pump_run_r;
  assign pump_multiplier_select_o = mult_r;
  assign target_cv_o = target_r;
  assign segment_count_o = seg_r;

endmodule : lsv_supply_ctrl

//--- tb/lsv_supply_ctrl_properties.sv
// Port checker for the supply control block.
// Assumes it is bound to lsv_supply_ctrl.
`timescale 1ns/10ps
module lsv_supply_ctrl_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] temp_offset_code_i,
  input wire logic pump_supply_ok_i,
  input wire logic pump_on_o,
  input wire logic pump_multiplier_select_o,
  input wire logic [10:0] target_cv_o,
  input wire logic [5:0] segment_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr_pump;
    s_req ##0 wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00;
  endsequence
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_taken: assert property (s_req |=> wb_ack_o)
    else $error("request not answered");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_seg_count: assert property (segment_count_o == 6'h2c || segment_count_o == 6'h2e)
    else $error("bad segment count");
  a_pump_supply: assert property (pump_on_o |-> $past(pump_supply_ok_i))
    else $error("pump on without supply");
  a_reset_out: assert property ($fell(rst_i) |-> !pump_on_o && !pump_multiplier_select_o)
    else $error("pump not off after reset");
  a_target_cause: assert property ($changed(target_cv_o) |-> $past(rst_i, 2) || $past(rst_i, 3)
    || $past(wb_ack_o && wb_we_i, 2) || $past(temp_offset_code_i) != $past(temp_offset_code_i, 2))
    else $error("target moved without cause");
  a_offs_read: assert property (s_req ##0 !wb_we_i && wb_adr_i == 8'h0c
    |=> wb_dat_o[7:0] == $past(temp_offset_code_i))
    else $error("offset read mismatch");
  a_mult_write: assert property (s_wr_pump |=> ##2 pump_multiplier_select_o == $past(wb_dat_i[0], 3))
    else $error("multiplier not updated");
endmodule : lsv_supply_ctrl_properties

//--- tb/lsv_host_model.sv
// Host model: classic Wishbone master issuing single transfers.
// Assumes the bench calls xfer from one process.
`timescale 1ns/10ps
module lsv_host_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  output logic timeout_o
);
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o, timeout_o} = 4'h0;
    {wb_adr_o, wb_sel_o, wb_dat_o} = 44'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'h3, w};
    {wb_adr_o, wb_sel_o, wb_dat_o} <= {a, s, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'h1 && n < 20);
    q = wb_dat_i;
    timeout_o <= (wb_ack_i !== 1'h1);
    {wb_cyc_o, wb_stb_o} <= 2'h0;
  endtask : xfer
endmodule : lsv_host_model

//--- tb/test_lsv_supply_ctrl.sv
// Self-checking bench for the supply control block.
// Assumes the host model drives the register bus.
`timescale 1ns/10ps
module test_lsv_supply_ctrl;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [7:0] offs = 8'h00;
  logic sup_ok = 1'h1;
  logic cyc, stb, we, ack, pon, mult, tmo;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [10:0] tgt;
  logic [5:0] seg;
  int errors = 0;
  int checked = 0;
  always #2 clk_i = ~clk_i;
  lsv_supply_ctrl i_lsv_supply_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .temp_offset_code_i(offs), .pump_supply_ok_i(sup_ok), .pump_on_o(pon),
    .pump_multiplier_select_o(mult), .target_cv_o(tgt), .segment_count_o(seg));
  lsv_host_model i_lsv_host_model (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .timeout_o(tmo));
  task end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_lsv_host_model.xfer(1'b1, a, d, 4'hf, q);
    repeat (3) @(posedge clk_i);
  endtask : wr
  function automatic logic [10:0] calc(input logic [7:0] c, input logic [7:0] o, input logic cp);
    return 11'(c) * 11'h003 + 11'h12c + (cp ? 11'($signed(o)) * 11'h003 : 11'h000);
  endfunction : calc
  task t_reset;
    i_lsv_host_model.xfer(1'h0, 8'h04, 32'h0, 4'hf, q);
    chk(q, 32'h2);
    i_lsv_host_model.xfer(1'h0, 8'h00, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    chk(32'(pon), 32'h0);
    chk(32'(tgt), 32'h12c);
    chk(32'(seg), 32'h2c);
  endtask : t_reset
  task t_target;
    logic [7:0] tab [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    wr(8'h08, 32'hff);
    for (int i = 0; i < 8; i++)
    begin
      offs <= tab[i % 4];
      wr(8'h04, 32'(i / 4) << 1);
      chk(32'(tgt), 32'(calc(8'hff, tab[i % 4], 1'(i / 4))));
      i_lsv_host_model.xfer(1'h0, 8'h0c, 32'h0, 4'hf, q);
      chk(q, 32'(tab[i % 4]));
      i_lsv_host_model.xfer(1'h0, 8'h18, 32'h0, 4'hf, q);
      chk(q, 32'(calc(8'hff, tab[i % 4], 1'(i / 4))));
    end
  endtask : t_target
  task t_pump;
    wr(8'h00, 32'h3);
    chk(32'({pon, mult}), 32'h3);
    wr(8'h00, 32'h1);
    chk(32'({pon, mult}), 32'h1);
    sup_ok <= 1'h0;
    wr(8'h00, 32'h3);
    chk(32'(pon), 32'h0);
    i_lsv_host_model.xfer(1'h0, 8'h14, 32'h0, 4'hf, q);
    chk(q, 32'h2c02);
    sup_ok <= 1'h1;
    i_lsv_host_model.xfer(1'h1, 8'h00, 32'h0, 4'he, q);
    repeat (3) @(posedge clk_i);
    chk(32'({pon, mult}), 32'h3);
    i_lsv_host_model.xfer(1'h0, 8'h14, 32'h0, 4'hf, q);
    chk(q, 32'h2c03);
    wr(8'h00, 32'h0);
  endtask : t_pump
  task t_ext;
    wr(8'h04, 32'h3);
    chk(32'(tgt), 32'h0);
    i_lsv_host_model.xfer(1'h0, 8'h14, 32'h0, 4'hf, q);
    chk(q, 32'h2c00);
    wr(8'h08, 32'h10);
    chk(32'(tgt), 32'h0);
    i_lsv_host_model.xfer(1'h0, 8'h18, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    wr(8'h04, 32'h2);
    chk(32'(tgt), 32'(calc(8'h10, offs, 1'h1)));
  endtask : t_ext
  task t_mux;
    for (int m = 0; m < 5; m++)
    begin
      wr(8'h10, 32'(m));
      chk(32'(seg), (m == 4) ? 32'h2e : 32'h2c);
    end
    i_lsv_host_model.xfer(1'h0, 8'h1c, 32'h0, 4'hf, q);
    chk(q, 32'h0);
  endtask : t_mux
  task t_rerun;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h3);
    chk(32'({pon, mult}), 32'h3);
    offs <= 8'h00;
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset;
  endtask : t_rerun
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset;
    t_target;
    t_pump;
    t_ext;
    t_mux;
    t_rerun;
    repeat (2) @(posedge clk_i);
    end_sim;
  end
  always @(posedge clk_i)
    if (tmo)
    begin
      errors++;
      end_sim;
    end
endmodule : test_lsv_supply_ctrl
bind lsv_supply_ctrl lsv_supply_ctrl_properties i_lsv_supply_ctrl_properties (.*);
